// ===== deac_regs.vh
`ifndef DEAC_REGS_VH
`define DEAC_REGS_VH
// Register byte offsets
`define DEAC_OFS_CTRL 8'h00
`define DEAC_OFS_KEY 8'h04
`define DEAC_OFS_ADDR 8'h08
`define DEAC_OFS_DATA 8'h0C
`define DEAC_OFS_STAT 8'h10
`define DEAC_OFS_MASK 8'h14
// Control register fields
`define DEAC_CTL_FLASH 7
`define DEAC_CTL_CONFIG_SPACE_SELECT 6
`define DEAC_CTL_FREE 4
`define DEAC_CTL_ERR 3
`define DEAC_CTL_PERMIT 2
`define DEAC_CTL_WR 1
`define DEAC_CTL_RD 0
// Status and mask fields
`define DEAC_ST_DONE 0
`define DEAC_ST_REFUSED 1
// Reset values
`define DEAC_CTRL_RST 8'h00
`define DEAC_ADDR_RST 8'h00
`define DEAC_DATA_RST 8'h00
`define DEAC_STAT_RST 2'h0
`define DEAC_MASK_RST 2'h0
// Unlock keys
`define DEAC_KEY1 8'h55
`define DEAC_KEY2 8'hAA
// Timing
`define DEAC_CLK_KHZ 200000
`define DEAC_PWRT_MS 72
`define DEAC_PWRT_CYC (`DEAC_PWRT_MS * `DEAC_CLK_KHZ)
`define DEAC_WRITE_US 4000
`define DEAC_WRITE_CYC (`DEAC_WRITE_US * (`DEAC_CLK_KHZ / 1000))
`endif

// ===== deac_ctrl.v
`timescale 1ns/100ps
`include "deac_regs.vh"
module deac_ctrl #(
  parameter ADDR_W = 8,
  parameter PWRT_CYC = `DEAC_PWRT_CYC,
  parameter WRITE_CYC = `DEAC_WRITE_CYC
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst_n,
  input wire ce,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Interrupt
  output wire irq,
  // Code-protect configuration pins
  input wire cp_read_pin,
  input wire cp_write_pin,
  // External programmer port
  input wire ext_rd_pin,
  input wire ext_wr_pin,
  input wire [ADDR_W-1:0] ext_addr,
  input wire [7:0] ext_wdata,
  output reg [7:0] ext_rdata,
  output reg ext_done,
  output reg ext_denied
);

  localparam DEPTH = 1 << ADDR_W;
  localparam ST_IDLE = 1'b0;
  localparam ST_WRITE = 1'b1;
  localparam UL_NONE = 2'd0;
  localparam UL_KEY1 = 2'd1;
  localparam UL_KEY2 = 2'd2;
  localparam [7:0] CTRL_RST = `DEAC_CTRL_RST;

  reg [7:0] mem [0:DEPTH-1];

  reg flash_select_reg;
  reg config_space_select_reg;
  reg free_reg;
  reg modify_permit_reg;
  reg wr_reg;
  reg rd_reg;
  reg [ADDR_W-1:0] nv_byte_address_reg;
  reg [7:0] nv_byte_value_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [1:0] unlock_reg;
  reg state_reg;
  reg [31:0] write_cnt_reg;
  reg [31:0] pwrt_cnt_reg;
  reg pwrt_done_reg;

  // Pin synchronisers: protect levels, strobes, programmer address and data
  localparam SYNC_CP_RD = 0;
  localparam SYNC_CP_WR = 1;
  localparam SYNC_RD = 2;
  localparam SYNC_WR = 3;
  localparam SYNC_ADDR = 4;
  localparam SYNC_DATA = SYNC_ADDR + ADDR_W;
  localparam SYNC_W = SYNC_DATA + 8;
  wire [SYNC_W-1:0] pin_raw;
  wire [SYNC_W-1:0] pin_sync;
  wire [ADDR_W-1:0] ext_addr_s;
  wire [7:0] ext_wdata_s;
  reg ext_rd_prev_reg;
  reg ext_wr_prev_reg;

  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  wire [7:0] wbyte;
  wire sel_ctrl;
  wire sel_key;
  wire sel_addr;
  wire sel_data;
  wire sel_stat;
  wire sel_mask;
  wire busy;
  wire wr_set_req;
  wire wr_start;
  wire wr_refused;
  wire rd_start;
  wire done_evt;
  wire cp_read;
  wire cp_write;
  wire ext_rd_evt;
  wire ext_wr_evt;
  wire [7:0] ctrl_view;
  wire [1:0] status_next;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd = bus_req & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];
  assign sel_ctrl = (wb_adr_i == `DEAC_OFS_CTRL);
  assign sel_key = (wb_adr_i == `DEAC_OFS_KEY);
  assign sel_addr = (wb_adr_i == `DEAC_OFS_ADDR);
  assign sel_data = (wb_adr_i == `DEAC_OFS_DATA);
  assign sel_stat = (wb_adr_i == `DEAC_OFS_STAT);
  assign sel_mask = (wb_adr_i == `DEAC_OFS_MASK);
  assign busy = (state_reg == ST_WRITE);

  assign pin_raw = {ext_wdata, ext_addr, ext_wr_pin, ext_rd_pin, cp_write_pin, cp_read_pin};
  assign cp_read = pin_sync[SYNC_CP_RD];
  assign cp_write = pin_sync[SYNC_CP_WR];
  // Address and data ride the same two stages as the strobe; the programmer
  // must hold them steady from the strobe rise until its answer
  assign ext_addr_s = pin_sync[SYNC_ADDR +: ADDR_W];
  assign ext_wdata_s = pin_sync[SYNC_DATA +: 8];
  assign ext_rd_evt = pin_sync[SYNC_RD] & ~ext_rd_prev_reg;
  assign ext_wr_evt = pin_sync[SYNC_WR] & ~ext_wr_prev_reg;

  // A start request is a control write asking for the start bit
  assign wr_set_req = bus_wr & sel_ctrl & ~busy & wbyte[`DEAC_CTL_WR];
  // Permit is judged on its stored value, so one write setting both fails
  assign wr_start = wr_set_req
    & modify_permit_reg
    & (unlock_reg == UL_KEY2)
    & pwrt_done_reg
    & ~wbyte[`DEAC_CTL_FLASH]
    & ~wbyte[`DEAC_CTL_CONFIG_SPACE_SELECT];
  assign wr_refused = wr_set_req & ~wr_start;
  assign rd_start = bus_wr & sel_ctrl & ~busy & wbyte[`DEAC_CTL_RD]
    & ~wbyte[`DEAC_CTL_FLASH]
    & ~wbyte[`DEAC_CTL_CONFIG_SPACE_SELECT];
  assign done_evt = ce & busy & (write_cnt_reg == 32'd0);

  assign ctrl_view = {flash_select_reg, config_space_select_reg, 1'b0, free_reg, 1'b0,
                      modify_permit_reg, wr_reg, rd_reg};
  assign irq = |(status_reg & mask_reg);

  // Bus handshake and read data
  always @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (bus_rd) begin
        if (sel_ctrl)
          wb_dat_o <= {24'h000000, ctrl_view};
        else if (sel_addr)
          wb_dat_o <= {{(32-ADDR_W){1'b0}}, nv_byte_address_reg};
        else if (sel_data)
          wb_dat_o <= {24'h000000, nv_byte_value_reg};
        else if (sel_stat)
          wb_dat_o <= {30'h0000000, status_reg};
        else if (sel_mask)
          wb_dat_o <= {30'h0000000, mask_reg};
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Two flip-flops per pin bit; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge mclk) begin
        if (!rst_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else if (ce) begin
          stage1_reg <= pin_raw[gi];
          stage2_reg <= stage1_reg;
        end
      end
      assign pin_sync[gi] = stage2_reg;
    end
  endgenerate

  // Edge detectors start at the idle level, so reset makes no false strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      ext_rd_prev_reg <= 1'b0;
      ext_wr_prev_reg <= 1'b0;
    end else if (ce) begin
      ext_rd_prev_reg <= pin_sync[SYNC_RD];
      ext_wr_prev_reg <= pin_sync[SYNC_WR];
    end
  end

  // Power-up lockout timer
  // It stops counting once done, so it cannot wrap and lock writes again
  always @(posedge mclk) begin
    if (!rst_n) begin
      pwrt_cnt_reg <= 32'd0;
      pwrt_done_reg <= 1'b0;
    end else if (ce && !pwrt_done_reg) begin
      if (pwrt_cnt_reg >= PWRT_CYC - 1)
        pwrt_done_reg <= 1'b1;
      else
        pwrt_cnt_reg <= pwrt_cnt_reg + 32'd1;
    end
  end

  // Unlock key sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      unlock_reg <= UL_NONE;
    end else if (ce && bus_req) begin
      if (wb_we_i && sel_key && wb_sel_i[0]) begin
        if (wbyte == `DEAC_KEY1)
          unlock_reg <= UL_KEY1;
        else if (wbyte == `DEAC_KEY2 && unlock_reg == UL_KEY1)
          unlock_reg <= UL_KEY2;
        else
          unlock_reg <= UL_NONE;
      end else begin
        // The start write consumes the key; anything else drops it
        unlock_reg <= UL_NONE;
      end
    end
  end

  // Control, address and data registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      flash_select_reg <= CTRL_RST[`DEAC_CTL_FLASH];
      config_space_select_reg <= CTRL_RST[`DEAC_CTL_CONFIG_SPACE_SELECT];
      free_reg <= CTRL_RST[`DEAC_CTL_FREE];
      modify_permit_reg <= CTRL_RST[`DEAC_CTL_PERMIT];
      rd_reg <= CTRL_RST[`DEAC_CTL_RD];
      nv_byte_address_reg <= `DEAC_ADDR_RST;
      nv_byte_value_reg <= `DEAC_DATA_RST;
    end else if (ce) begin
      if (rd_reg) begin
        nv_byte_value_reg <= mem[nv_byte_address_reg];
        rd_reg <= 1'b0;
      end
      if (bus_wr && !busy) begin
        if (sel_ctrl) begin
          flash_select_reg <= wbyte[`DEAC_CTL_FLASH];
          config_space_select_reg <= wbyte[`DEAC_CTL_CONFIG_SPACE_SELECT];
          free_reg <= wbyte[`DEAC_CTL_FREE];
          // Only software changes the permit bit
          modify_permit_reg <= wbyte[`DEAC_CTL_PERMIT];
          if (rd_start)
            rd_reg <= 1'b1;
        end
        if (sel_addr)
          nv_byte_address_reg <= wb_dat_i[ADDR_W-1:0];
        if (sel_data)
          nv_byte_value_reg <= wbyte;
      end
    end
  end

  // Self-timed write engine
  // Loaded with one less, so the cycle ends on the WRITE_CYC-th edge
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wr_reg <= 1'b0;
      write_cnt_reg <= 32'd0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_start) begin
            state_reg <= ST_WRITE;
            wr_reg <= 1'b1;
            write_cnt_reg <= WRITE_CYC - 1;
          end
        end
        ST_WRITE: begin
          if (write_cnt_reg == 32'd0) begin
            state_reg <= ST_IDLE;
            wr_reg <= 1'b0;
          end else begin
            write_cnt_reg <= write_cnt_reg - 32'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          wr_reg <= 1'b0;
        end
      endcase
    end
  end

  // Array writes: processor path always, programmer only when unprotected
  // A programmer write that meets the end of a cycle is refused, not merged
  always @(posedge mclk) begin
    if (ce) begin
      if (done_evt)
        mem[nv_byte_address_reg] <= nv_byte_value_reg;
      else if (ext_wr_evt && !cp_write && !busy && pwrt_done_reg)
        mem[ext_addr_s] <= ext_wdata_s;
    end
  end

  // External programmer answers
  always @(posedge mclk) begin
    if (!rst_n) begin
      ext_rdata <= 8'h00;
      ext_done <= 1'b0;
      ext_denied <= 1'b0;
    end else if (ce) begin
      ext_done <= 1'b0;
      ext_denied <= 1'b0;
      if (ext_rd_evt) begin
        if (cp_read) begin
          ext_denied <= 1'b1;
        end else begin
          ext_rdata <= mem[ext_addr_s];
          ext_done <= 1'b1;
        end
      end else if (ext_wr_evt) begin
        if (cp_write || busy || done_evt || !pwrt_done_reg)
          ext_denied <= 1'b1;
        else
          ext_done <= 1'b1;
      end
    end
  end

  // Interrupt mask, same layout as the status flags
  always @(posedge mclk) begin
    if (!rst_n) begin
      mask_reg <= `DEAC_MASK_RST;
    end else if (ce && bus_wr && sel_mask) begin
      mask_reg <= wbyte[1:0];
    end
  end

  // Sticky status; a read clears, but a new event in that cycle wins
  assign status_next = ((bus_rd && sel_stat) ? 2'b00 : status_reg) | {wr_refused, done_evt};

  always @(posedge mclk) begin
    if (!rst_n) begin
      status_reg <= `DEAC_STAT_RST;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

endmodule // deac_ctrl

// ===== deac_ctrl_assertions.sv
`timescale 1ns/100ps
module deac_ctrl_assertions (
  // Clock, reset and enable
  input wire mclk,
  input wire rst_n,
  input wire ce,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Interrupt and programmer
  input wire irq,
  input wire ext_done,
  input wire ext_denied
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire ans = ext_done || ext_denied;
  chk_ack_next: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o || !ce)
    else $error("ack late");
  chk_ack_pulse: assert property (ce && wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_read_clear: assert property (rd_ack && wb_adr_i == 8'h00 |-> !wb_dat_o[0]) else $error("read bit set");
  chk_key_zero: assert property (rd_ack && wb_adr_i == 8'h04 |-> wb_dat_o == 32'h0) else $error("key read");
  // Read data may only move on the edge that answers a read
  chk_data_hold: assert property ($past(rst_n) && !rd_ack |-> $stable(wb_dat_o)) else $error("data moved");
  chk_irq_clear: assert property ($fell(irq) |-> wb_ack_o) else $error("irq dropped alone");
  chk_ext_excl: assert property (!(ext_done && ext_denied)) else $error("done with denied");
  chk_ext_pulse: assert property (ce && ans |=> !ans) else $error("answer too long");
  cover property ($rose(irq));
  cover property (ext_denied);
  cover property (ext_done);
endmodule // deac_ctrl_assertions

bind deac_ctrl deac_ctrl_assertions u_deac_ctrl_assertions (.mclk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq, .ext_done, .ext_denied);

// ===== deac_prog_model.sv
`timescale 1ns/100ps
module deac_prog_model (
  // Clock
  input wire mclk,
  // Programmer port
  output logic ext_rd_pin = 1'h0,
  output logic ext_wr_pin = 1'h0,
  output logic [7:0] ext_addr = 8'h00,
  output logic [7:0] ext_wdata = 8'h00,
  input wire [7:0] ext_rdata,
  input wire ext_done,
  input wire ext_denied
);
  // Operands held until the answer, then scrambled so stale values never pass;
  // only the bench watchdog ends a wait
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic ok, output logic [7:0] q);
    @(posedge mclk);
    ext_rd_pin <= !wr;
    ext_wr_pin <= wr;
    ext_addr <= a;
    ext_wdata <= d;
    do @(posedge mclk); while (!(ext_done === 1'h1 || ext_denied === 1'h1));
    ok = ext_done;
    q = ext_rdata;
    ext_rd_pin <= 1'h0;
    ext_wr_pin <= 1'h0;
    ext_addr <= ~a;
    ext_wdata <= ~d;
  endtask
endmodule // deac_prog_model

// ===== test_deac_ctrl.sv
`timescale 1ns/100ps
`include "deac_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module test_deac_ctrl;
  localparam logic [7:0] CT = `DEAC_OFS_CTRL, KY = `DEAC_OFS_KEY, AD = `DEAC_OFS_ADDR, DT = `DEAC_OFS_DATA;
  logic mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cp_read_pin = 0, cp_write_pin = 0, ok;
  logic ce = 1;
  logic [7:0] wb_adr_i = 0, q, pq, a, d;
  logic [31:0] wb_dat_i = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq, ext_rd_pin, ext_wr_pin, ext_done, ext_denied;
  wire [7:0] ext_addr, ext_wdata, ext_rdata;
  int bad_count = 0, n_compared = 0, seed = 52271, k, j;
  deac_ctrl #(.PWRT_CYC(40), .WRITE_CYC(40)) u_deac_ctrl (.mclk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .cp_read_pin, .cp_write_pin, .ext_rd_pin,
    .ext_wr_pin, .ext_addr, .ext_wdata, .ext_rdata, .ext_done, .ext_denied);
  deac_prog_model u_deac_prog_model (.mclk, .ext_rd_pin, .ext_wr_pin, .ext_addr, .ext_wdata, .ext_rdata, .ext_done,
    .ext_denied);
  initial forever #2.5 mclk = ~mclk;
  // Run needs under two thousand cycles; this limit only cuts a hang
  initial begin
    #50000;
    bad_count++;
    end_of_test;
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] st_exp(input logic done);
    return done ? 8'h01 : 8'h02;
  endfunction
  // Waits for ack however long it takes; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] ba, input logic [7:0] bd);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= ba;
    wb_dat_i <= {24'h0, bd};
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_dat_i <= ~wb_dat_i;
  endtask
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    bus(1'h1, wa, wd);
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    bus(1'h0, ra, 8'h00);
    `CHK(q, e)
  endtask
  task automatic unlock(input logic [7:0] p, input logic [7:0] c);
    wr(CT, p);
    // Nothing services the interrupt between the keys and the start
    wr(KY, `DEAC_KEY1);
    wr(KY, `DEAC_KEY2);
    wr(CT, c);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    rd(CT, 8'h00);
    unlock(8'h04, 8'h06);
    rd(`DEAC_OFS_STAT, st_exp(1'h0));
    repeat (40) @(posedge mclk);
    wr(`DEAC_OFS_MASK, 8'h01);
    cp_read_pin <= 1'h1;
    cp_write_pin <= 1'h1;
    for (k = 0; k < 4; k++) begin
      {a, d} = 16'($random(seed));
      if (k == 0) a = 8'hFF;
      wr(AD, a);
      wr(DT, d);
      unlock(8'h04, 8'h06);
      rd(CT, 8'h06);
      if (k == 1) begin
        // A low clock enable must stall the write timer past its length
        ce <= 1'h0;
        repeat (50) @(posedge mclk);
        ce <= 1'h1;
        rd(CT, 8'h06);
      end
      wr(AD, ~a);
      wr(CT, 8'h00);
      rd(AD, a);
      j = 0;
      do begin
        bus(1'h0, CT, 8'h00);
        j++;
      end while (q[1] && j < 50);
      `CHK(q, 8'h04)
      `CHK(irq, 1'h1)
      rd(`DEAC_OFS_STAT, st_exp(1'h1));
      #1;
      `CHK(irq, 1'h0)
      wr(DT, ~d);
      wr(CT, 8'h01);
      rd(DT, d);
    end
    $display("write loop done");
    wr(DT, 8'hEE);
    rd(KY, 8'h00);
    wr(CT, 8'h04);
    for (k = 0; k < 5; k++) begin
      if (k > 1) unlock(k == 2 ? 8'h00 : 8'h04, k == 2 ? 8'h06 : k == 3 ? 8'h86 : 8'h46);
      else begin
        wr(KY, k ? `DEAC_KEY1 : `DEAC_KEY2);
        if (k) bus(1'h0, AD, 8'h00);
        wr(KY, k ? `DEAC_KEY2 : `DEAC_KEY1);
        wr(CT, 8'h06);
      end
      #1;
      `CHK(irq, 1'h0)
      rd(`DEAC_OFS_STAT, st_exp(1'h0));
    end
    wr(CT, 8'h81);
    rd(DT, 8'hEE);
    wr(CT, 8'h01);
    rd(DT, d);
    u_deac_prog_model.xfer(1'h0, a, 8'h00, ok, pq);
    `CHK(ok, 1'h0)
    u_deac_prog_model.xfer(1'h1, a, 8'h00, ok, pq);
    `CHK(ok, 1'h0)
    cp_read_pin <= 1'h0;
    cp_write_pin <= 1'h0;
    repeat (3) @(posedge mclk);
    u_deac_prog_model.xfer(1'h0, a, 8'h00, ok, pq);
    `CHK(ok, 1'h1)
    `CHK(pq, d)
    u_deac_prog_model.xfer(1'h1, ~a, ~d, ok, pq);
    `CHK(ok, 1'h1)
    wr(AD, ~a);
    wr(CT, 8'h01);
    rd(DT, ~d);
    $display("refusal and protect tests done");
    end_of_test;
  end
endmodule // test_deac_ctrl
